// ### hw/serial_pkg.sv
package serial_pkg;
    localparam logic [7:0] IDX_CONTROL = 8'h0d;
    localparam logic [7:0] IDX_STATUS  = 8'h0e;
    localparam logic [7:0] IDX_DATA    = 8'h0f;
    localparam logic [7:0] IDX_BUFFER  = 8'h10;
    localparam int CTL_SIE = 7;
    localparam int CTL_OIE = 6;
    localparam int CTL_WM  = 4;
    localparam int CTL_CS  = 2;
    localparam int CTL_CLK = 1;
    localparam int CTL_TC  = 0;
    localparam int ST_SIF  = 7;
    localparam int ST_OIF  = 6;
    localparam int ST_PF   = 5;
    localparam logic [1:0] WM_OFF      = 2'h0;
    localparam logic [1:0] WM_THREE    = 2'h1;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;
    localparam logic [1:0] CS_SOFT     = 2'h0;
    localparam logic [1:0] CS_TIMER    = 2'h1;
    localparam logic [1:0] CS_EXT_POS  = 2'h2;
    localparam logic [1:0] CS_EXT_NEG  = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] CNT_MAX     = 4'hf;
    localparam logic [7:0] DATA_RST    = 8'h00;
    localparam logic [3:0] CNT_RST     = 4'h0;
    localparam logic       PORT_RST    = 1'h1;
    localparam logic       PIN_IDLE    = 1'h1;
    typedef enum logic { WR_COLLECT, WR_RESP } wr_state_e;
    typedef struct packed {
        logic       sie;
        logic       oie;
        logic [1:0] wm;
        logic [1:0] cs;
        logic       soft_count;
    } ctrl_s;
    localparam ctrl_s CTRL_RST = 7'h00;
    typedef struct packed {
        logic clk_in;
        logic data_in;
    } pin_in_s;
    typedef struct packed {
        logic clk_dir;
        logic sda_dir;
        logic do_dir;
    } pin_dir_s;
    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic sda_o;
        logic sda_oe;
        logic do_o;
        logic do_oe;
    } pin_out_s;
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {idx[5:0], 2'h0});
    endfunction
endpackage

// ### hw/serial_shift_two_wire_unit.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module serial_shift_two_wire_unit (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // axi4-lite read
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // core side
    input  wire logic               timer_match,
    input  wire logic               global_irq_enable,
    output logic                    start_irq,
    output logic                    wrap_irq,
    // pins
    input  wire serial_pkg::pin_in_s  pins_in,
    input  wire serial_pkg::pin_dir_s pins_dir,
    output serial_pkg::pin_out_s      pins_out
);
    import serial_pkg::*;

    typedef struct packed {
        wr_state_e  wr;
        logic       aw_got;
        logic [7:0] aw_addr;
        logic       w_got;
        logic [7:0] w_data;
        logic       w_lane0;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        ctrl_s      ctl;
        logic [7:0] data;
        logic [7:0] buffer;
        logic [3:0] cnt;
        logic       sif;
        logic       oif;
        logic       pf;
        logic       start_hold;
        logic       port_bit;
        logic       latch;
        logic       clk_s1;
        logic       clk_s2;
        logic       clk_s3;
        logic       dat_s1;
        logic       dat_s2;
        logic       dat_s3;
    } st_s;

    st_s s_q;
    st_s s_d;

    logic       two_wire;
    logic       clk_rise;
    logic       clk_fall;
    logic       dat_rise;
    logic       dat_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       edge_start;
    logic       do_wr;
    logic       wr_ctl;
    logic       wr_status;
    logic       wr_data;
    logic       wr_map;
    logic       strobe_clk;
    logic       strobe_tc;
    logic       rd_take;
    logic       rd_buf;
    logic       shift_ev;
    logic       cnt_ev;
    logic       wrap;
    logic       transparent;
    logic       dout;
    logic       hold;
    logic       mismatch;
    logic [7:0] status_v;
    logic [7:0] control_v;
    logic [7:0] rd_v;
    logic       rd_map;

    // synchronised pin edges
    assign two_wire   = s_q.ctl.wm[1];
    assign clk_rise   = s_q.clk_s2 & ~s_q.clk_s3;
    assign clk_fall   = ~s_q.clk_s2 & s_q.clk_s3;
    assign dat_rise   = s_q.dat_s2 & ~s_q.dat_s3;
    assign dat_fall   = ~s_q.dat_s2 & s_q.dat_s3;
    assign start_cond = two_wire & dat_fall & s_q.clk_s2;
    assign stop_cond  = two_wire & dat_rise & s_q.clk_s2;
    assign edge_start = ~two_wire & s_q.ctl.cs[1] & ~s_q.ctl.soft_count
                      & (clk_rise | clk_fall);

    // register bus decode
    assign awready    = (s_q.wr == WR_COLLECT) & ~s_q.aw_got;
    assign wready     = (s_q.wr == WR_COLLECT) & ~s_q.w_got;
    assign bvalid     = (s_q.wr == WR_RESP);
    assign bresp      = s_q.bresp;
    assign arready    = ~s_q.rvalid;
    assign rvalid     = s_q.rvalid;
    assign rdata      = {24'h000000, s_q.rdata};
    assign rresp      = s_q.rresp;
    assign do_wr      = (s_q.wr == WR_COLLECT) & s_q.aw_got & s_q.w_got;
    assign wr_map     = reg_hit(s_q.aw_addr, IDX_CONTROL) | reg_hit(s_q.aw_addr, IDX_STATUS)
                      | reg_hit(s_q.aw_addr, IDX_DATA) | reg_hit(s_q.aw_addr, IDX_BUFFER);
    assign wr_ctl     = do_wr & s_q.w_lane0 & reg_hit(s_q.aw_addr, IDX_CONTROL);
    assign wr_status  = do_wr & s_q.w_lane0 & reg_hit(s_q.aw_addr, IDX_STATUS);
    assign wr_data    = do_wr & s_q.w_lane0 & reg_hit(s_q.aw_addr, IDX_DATA);
    assign strobe_clk = wr_ctl & s_q.w_data[CTL_CLK];
    assign strobe_tc  = wr_ctl & s_q.w_data[CTL_TC];
    assign rd_take    = arvalid & arready;
    assign rd_buf     = rd_take & reg_hit(araddr, IDX_BUFFER);

    // clock source selection
    always_comb begin
        shift_ev = 1'b0;
        cnt_ev   = 1'b0;
        case (s_q.ctl.cs)
            CS_SOFT: begin
                shift_ev = strobe_clk;
                cnt_ev   = strobe_clk;
            end
            CS_TIMER: begin
                shift_ev = timer_match;
                cnt_ev   = timer_match;
            end
            CS_EXT_POS: begin
                shift_ev = clk_rise;
                cnt_ev   = s_q.ctl.soft_count ? strobe_tc : (clk_rise | clk_fall);
            end
            default: begin
                shift_ev = clk_fall;
                cnt_ev   = s_q.ctl.soft_count ? strobe_tc : (clk_rise | clk_fall);
            end
        endcase
    end

    assign wrap = cnt_ev & ~wr_status & (s_q.cnt == CNT_MAX);

    // output latch, open half cycle with external clock
    assign transparent = ~s_q.ctl.cs[1] | (s_q.clk_s2 == s_q.ctl.cs[0]);
    assign dout        = transparent ? s_q.data[7] : s_q.latch;
    assign mismatch    = two_wire & (s_q.data[7] != s_q.dat_s2);
    assign hold        = two_wire & (s_q.start_hold
                       | ((s_q.ctl.wm == WM_TWO_HOLD) & s_q.oif));
    assign status_v    = {s_q.sif, s_q.oif, s_q.pf, mismatch, s_q.cnt};
    assign control_v   = {s_q.ctl.sie, s_q.ctl.oie, s_q.ctl.wm, s_q.ctl.cs, 2'h0};

    always_comb begin
        rd_map = 1'b1;
        if (reg_hit(araddr, IDX_CONTROL)) begin
            rd_v = control_v;
        end else if (reg_hit(araddr, IDX_STATUS)) begin
            rd_v = status_v;
        end else if (reg_hit(araddr, IDX_DATA)) begin
            rd_v = s_q.data;
        end else if (reg_hit(araddr, IDX_BUFFER)) begin
            rd_v = s_q.buffer;
        end else begin
            rd_v   = 8'h00;
            rd_map = 1'b0;
        end
    end

    // pin drivers, two-wire lines only pulled low
    always_comb begin
        pins_out = '0;
        pins_out.do_o = dout;
        pins_out.do_oe = (s_q.ctl.wm == WM_THREE) & pins_dir.do_dir;
        if (two_wire) begin
            pins_out.clk_o  = 1'b0;
            pins_out.clk_oe = hold | (pins_dir.clk_dir & ~s_q.port_bit);
            pins_out.sda_o  = 1'b0;
            pins_out.sda_oe = pins_dir.sda_dir & ~dout;
        end else if (s_q.ctl.wm == WM_THREE) begin
            pins_out.clk_o  = s_q.port_bit;
            pins_out.clk_oe = pins_dir.clk_dir;
        end
    end

    assign start_irq = s_q.sif & s_q.ctl.sie & global_irq_enable;
    assign wrap_irq  = s_q.oif & s_q.ctl.oie & global_irq_enable;

    always_comb begin
        s_d = s_q;
        s_d.clk_s1 = pins_in.clk_in;
        s_d.clk_s2 = s_q.clk_s1;
        s_d.clk_s3 = s_q.clk_s2;
        s_d.dat_s1 = pins_in.data_in;
        s_d.dat_s2 = s_q.dat_s1;
        s_d.dat_s3 = s_q.dat_s2;
        // write channel
        if (awvalid && awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            s_d.w_got   = 1'b1;
            s_d.w_data  = wdata[7:0];
            s_d.w_lane0 = wstrb[0];
        end
        case (s_q.wr)
            WR_COLLECT: begin
                if (do_wr) begin
                    s_d.wr     = WR_RESP;
                    s_d.aw_got = 1'b0;
                    s_d.w_got  = 1'b0;
                    s_d.bresp  = wr_map ? RESP_OKAY : RESP_SLVERR;
                end
            end
            default: begin
                if (bready) begin
                    s_d.wr = WR_COLLECT;
                end
            end
        endcase
        // read channel
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_take) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_v;
            s_d.rresp  = rd_map ? RESP_OKAY : RESP_SLVERR;
        end
        // control
        if (wr_ctl) begin
            s_d.ctl.sie        = s_q.w_data[CTL_SIE];
            s_d.ctl.oie        = s_q.w_data[CTL_OIE];
            s_d.ctl.wm         = s_q.w_data[CTL_WM+1:CTL_WM];
            s_d.ctl.cs         = s_q.w_data[CTL_CS+1:CTL_CS];
            s_d.ctl.soft_count = s_q.w_data[CTL_CLK];
        end
        if (strobe_tc) begin
            s_d.port_bit = ~s_q.port_bit;
        end
        // shift register, write wins over shift; shifts left only, pin level in at bit 0, top bit out
        if (wr_data) begin
            s_d.data = s_q.w_data;
        end else if (shift_ev) begin
            s_d.data = {s_q.data[6:0], s_q.dat_s2};
        end
        if (transparent) begin
            s_d.latch = s_q.data[7];
        end
        // edge counter; software preload to 14 gives one-bit acknowledge
        if (wr_status) begin
            s_d.cnt = s_q.w_data[3:0];
        end else if (cnt_ev) begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
        if (wrap) begin
            s_d.buffer = s_d.data;
        end
        // flags: set beats clear
        if ((wr_status && s_q.w_data[ST_OIF]) || rd_buf) begin
            s_d.oif = 1'b0;
        end
        if (wrap) begin
            s_d.oif = 1'b1;
        end
        if (wr_status && s_q.w_data[ST_SIF]) begin
            s_d.sif = 1'b0;
        end
        if (start_cond || edge_start) begin
            s_d.sif = 1'b1;
        end
        if (wr_status && s_q.w_data[ST_PF]) begin
            s_d.pf = 1'b0;
        end
        if (stop_cond) begin
            s_d.pf = 1'b1;
        end
        // clock stretch after start, released with the start flag
        if (!s_d.sif || !two_wire) begin
            s_d.start_hold = 1'b0;
        end else if (s_q.sif && clk_fall) begin
            s_d.start_hold = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q            <= '0;
            s_q.wr         <= WR_COLLECT;
            s_q.ctl        <= CTRL_RST;
            s_q.data       <= DATA_RST;
            s_q.buffer     <= DATA_RST;
            s_q.cnt        <= CNT_RST;
            s_q.port_bit   <= PORT_RST;
            // synchronisers start at the idle bus level, no false edge after reset
            s_q.clk_s1     <= PIN_IDLE;
            s_q.clk_s2     <= PIN_IDLE;
            s_q.clk_s3     <= PIN_IDLE;
            s_q.dat_s1     <= PIN_IDLE;
            s_q.dat_s2     <= PIN_IDLE;
            s_q.dat_s3     <= PIN_IDLE;
            s_q.bresp      <= RESP_OKAY;
            s_q.rresp      <= RESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_start_set: assert property (start_cond |=> s_q.sif)
        else $error("start condition did not set flag");
    chk_start_mode: assert property (!two_wire && !edge_start |=> !$rose(s_q.sif))
        else $error("start flag rose outside two-wire mode");
    chk_start_hold: assert property (two_wire && s_q.sif && clk_fall && !wr_status
        |=> pins_out.clk_oe && !pins_out.clk_o)
        else $error("clock not held after start");
    chk_hold_release: assert property ($fell(s_q.sif) |-> !s_q.start_hold)
        else $error("start hold kept after flag clear");
    chk_shift_in: assert property (shift_ev && !wr_data
        |=> s_q.data == {$past(s_q.data[6:0]), $past(s_q.dat_s2)})
        else $error("shift did not take data input");
    chk_write_wins: assert property (wr_data |=> s_q.data == $past(s_q.w_data))
        else $error("shift overrode software write");
    chk_wrap_hold: assert property (s_q.ctl.wm == WM_TWO_HOLD && s_q.oif
        |-> pins_out.clk_oe && !pins_out.clk_o)
        else $error("clock not held after wrap");
    chk_count_both: assert property (s_q.ctl.cs[1] && !s_q.ctl.soft_count
        && (clk_rise || clk_fall) && !wr_status
        |=> s_q.cnt == $past(s_q.cnt) + 4'h1)
        else $error("pin edge not counted");
    chk_wrap_flag: assert property (cnt_ev && !wr_status && s_q.cnt == CNT_MAX
        |=> s_q.oif && s_q.cnt == 4'h0)
        else $error("wrap flag missing");
    chk_wrap_clear: assert property (rd_buf && !wrap |=> !s_q.oif)
        else $error("buffer read did not clear wrap flag");
    chk_latch_open: assert property (!s_q.ctl.cs[1] |-> pins_out.do_o == s_q.data[7])
        else $error("open latch not passing top bit");
    chk_latch_closed: assert property (!transparent && $stable(s_q.clk_s2)
        ##1 !transparent |-> $stable(pins_out.do_o))
        else $error("closed latch changed output");
    chk_edge_start: assert property (edge_start |=> s_q.sif)
        else $error("clock edge did not set start flag");
    chk_stop_seen: assert property (stop_cond |=> s_q.pf)
        else $error("stop not flagged");
    chk_cnt_write: assert property (wr_status |=> s_q.cnt == $past(s_q.w_data[3:0]))
        else $error("counter write lost");
    chk_no_high: assert property (two_wire |-> !(pins_out.clk_oe && pins_out.clk_o)
        && !(pins_out.sda_oe && pins_out.sda_o))
        else $error("two-wire line driven high");
    chk_bus_resp: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    chk_timer_shift: assert property (s_q.ctl.cs == CS_TIMER && timer_match && !wr_data
        |=> s_q.data == {$past(s_q.data[6:0]), $past(s_q.dat_s2)})
        else $error("timer match did not shift");
    chk_strobe_count: assert property (strobe_clk && s_q.ctl.cs == CS_SOFT
        |=> s_q.cnt == $past(s_q.cnt) + 4'h1)
        else $error("shift strobe not counted");

    cov_start: cover property (start_cond ##[1:200] s_q.start_hold);
    cov_wrap: cover property (wrap ##1 rd_buf);
    cov_stop: cover property (stop_cond);
    cov_read: cover property (rd_take ##1 rvalid && rready);
endmodule

// ### dv/two_wire_master.sv
`timescale 1ns/1ps
module two_wire_master (
    // bus levels
    input  wire logic scl,
    // open-drain pull-downs
    output logic      scl_low,
    output logic      sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // release clock, then wait while a slave stretches it
    task automatic scl_up();
        scl_low = 1'b0;
        for (int i = 0; i < 400 && scl !== 1'b1; i++) #5;
    endtask
    task automatic start();
        sda_low = 1'b1;
        #32;
        scl_low = 1'b1;
        #32;
    endtask
    // data changes only while clock is low
    task automatic bit_out(input logic b);
        sda_low = !b;
        #32;
        scl_up();
        #32;
        scl_low = 1'b1;
        #32;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #32;
        scl_up();
        #32;
        sda_low = 1'b0;
        #32;
    endtask
    task automatic pulse();
        scl_low = 1'b1;
        #32;
        scl_low = 1'b0;
        #32;
    endtask
endmodule

// ### dv/serial_shift_two_wire_unit_tb.sv
`timescale 1ns/1ps
module serial_shift_two_wire_unit_tb;
    import serial_pkg::*;
    localparam logic [7:0] A_CTL = {IDX_CONTROL[5:0], 2'h0};
    localparam logic [7:0] A_ST  = {IDX_STATUS[5:0], 2'h0};
    localparam logic [7:0] A_DAT = {IDX_DATA[5:0], 2'h0};
    localparam logic [7:0] A_BUF = {IDX_BUFFER[5:0], 2'h0};
    localparam logic [7:0] ADDR_BYTE = 8'ha5;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp, wr_resp;
    logic        gie = 1'b1, tmatch = 1'b0;
    logic        start_irq, wrap_irq, scl_low, sda_low;
    pin_in_s     pins_in;
    pin_dir_s    pins_dir = 3'h0;
    pin_out_s    pins_out;
    wire         scl = !(scl_low || (pins_out.clk_oe && !pins_out.clk_o));
    wire         sda = !(sda_low || (pins_out.sda_oe && !pins_out.sda_o));
    int          n_errors = 0, n_compared = 0;
    logic [31:0] d;
    assign pins_in = {scl, sda};
    always #2.5 aclk = ~aclk;

    serial_shift_two_wire_unit DUT (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .timer_match(tmatch), .global_irq_enable(gie),
        .start_irq(start_irq), .wrap_irq(wrap_irq),
        .pins_in(pins_in), .pins_dir(pins_dir), .pins_out(pins_out)
    );
    two_wire_master M (.scl(scl), .scl_low(scl_low), .sda_low(sda_low));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw_d, w_d;
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        aw_d = 1'b0;
        w_d = 1'b0;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin aw_d = 1'b1; awvalid <= 1'b0; end
            if (wvalid && wready === 1'b1) begin w_d = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // drive mismatch bit is masked where the pin level is not pinned down
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a, d, resp);
        chk(d & {24'h0, m}, {24'h0, e});
    endtask
    task automatic stop_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(A_ST, 8'hff, 8'h00);
        rdc(A_CTL, 8'hff, 8'h00);
        rd(8'h00, d, resp);
        chk(resp, RESP_SLVERR);
        chk(d, 32'h0);
        wr(8'h00, 8'h00);
        chk(wr_resp, RESP_SLVERR);
        // counter read and write through status
        wr(A_ST, 8'h0a);
        chk(wr_resp, RESP_OKAY);
        rdc(A_ST, 8'h0f, 8'h0a);
        // no wire mode, falling pin edge select: both edges count and set start flag
        wr(A_DAT, 8'h00);
        wr(A_ST, 8'hf0);
        wr(A_CTL, 8'h0c);
        M.pulse();
        repeat (8) @(posedge aclk);
        rdc(A_ST, 8'hef, 8'h82);
        rdc(A_DAT, 8'hff, 8'h01);
        // software strobe from a full counter
        wr(A_DAT, 8'h81);
        chk(pins_out.do_o, 1'b1);
        wr(A_ST, 8'hef);
        wr(A_CTL, 8'h40);
        wr(A_CTL, 8'h42);
        rdc(A_ST, 8'hef, 8'h40);
        chk(wrap_irq, 1'b1);
        gie <= 1'b0;
        @(posedge aclk);
        @(posedge aclk);
        chk(wrap_irq, 1'b0);
        gie <= 1'b1;
        rdc(A_BUF, 8'hff, 8'h03);
        rdc(A_ST, 8'hef, 8'h00);
        // timer compare as shift clock
        wr(A_CTL, 8'h04);
        tmatch <= 1'b1;
        @(posedge aclk);
        tmatch <= 1'b0;
        rdc(A_ST, 8'h0f, 8'h01);
        rdc(A_DAT, 8'hff, 8'h07);
        // three-wire outputs follow top bit and port bit
        pins_dir <= 3'h1;
        wr(A_CTL, 8'h10);
        chk(pins_out.do_oe, 1'b1);
        chk(pins_out.do_o, 1'b0);
        chk(pins_out.clk_o, 1'b1);
        wr(A_CTL, 8'h11);
        chk(pins_out.clk_o, 1'b0);
        wr(A_CTL, 8'h11);
        chk(pins_out.clk_o, 1'b1);
        // two-wire slave receiving an address byte
        pins_dir <= 3'h6;
        wr(A_DAT, 8'hff);
        wr(A_ST, 8'hf0);
        wr(A_CTL, 8'hb8);
        M.start();
        repeat (4) @(posedge aclk);
        rdc(A_ST, 8'h80, 8'h80);
        chk(start_irq, 1'b1);
        chk(pins_out.clk_oe, 1'b1);
        chk({pins_out.clk_o, pins_out.sda_o}, 2'h0);
        wr(A_ST, 8'h80);
        repeat (4) @(posedge aclk);
        chk(pins_out.clk_oe, 1'b0);
        chk(start_irq, 1'b0);
        for (int i = 7; i >= 0; i--)
            M.bit_out(ADDR_BYTE[i]);
        repeat (4) @(posedge aclk);
        chk(pins_out.clk_oe, 1'b1);
        rdc(A_ST, 8'hef, 8'h40);
        rdc(A_DAT, 8'hff, 8'ha5);
        // acknowledge: low top bit pulls data, counter preset for one bit
        wr(A_DAT, 8'h7f);
        wr(A_ST, 8'h0e);
        rdc(A_BUF, 8'hff, 8'ha5);
        repeat (4) @(posedge aclk);
        chk(pins_out.clk_oe, 1'b0);
        chk(scl, 1'b0);
        chk(sda, 1'b0);
        M.bit_out(1'b1);
        repeat (4) @(posedge aclk);
        chk(pins_out.clk_oe, 1'b1);
        rdc(A_DAT, 8'hff, 8'hfe);
        rdc(A_ST, 8'hef, 8'h40);
        wr(A_ST, 8'h40);
        repeat (4) @(posedge aclk);
        chk(pins_out.clk_oe, 1'b0);
        M.stop();
        repeat (8) @(posedge aclk);
        rdc(A_ST, 8'h20, 8'h20);
        wr(A_ST, 8'h20);
        rdc(A_ST, 8'h20, 8'h00);
        stop_test();
    end
endmodule
